// *** common/flps_pkg.sv ***
// Constants, command codes and carrier types for the sector protection block
package flps_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int SECTORS = 46;
    localparam int GROUPS = 24;
    localparam int SEC_W = 6;
    localparam int GRP_W = 5;
    localparam logic [SEC_W-1:0] BOOT_LO_LAST = 6'h07;
    localparam logic [SEC_W-1:0] BOOT_HI_FIRST = 6'h26;
    localparam logic [SEC_W-1:0] MID_FIRST_GRP_END = 6'h0A;
    localparam logic [SEC_W-1:0] MID_LAST_GRP_START = 6'h23;
    localparam logic [SEC_W-1:0] WP_SEC_A = 6'h00;
    localparam logic [SEC_W-1:0] WP_SEC_B = 6'h01;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PWD_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PWD_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_VERIFY = 8'h10;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SEC_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [3:0] OP_PROGRAM = 4'h1;
    localparam logic [3:0] OP_ERASE = 4'h2;
    localparam logic [3:0] OP_NV_SET = 4'h3;
    localparam logic [3:0] OP_NV_ERASE = 4'h4;
    localparam logic [3:0] OP_VOL_SET = 4'h5;
    localparam logic [3:0] OP_VOL_CLR = 4'h6;
    localparam logic [3:0] OP_FREEZE_SET = 4'h7;
    localparam logic [3:0] OP_PERS_LOCK = 4'h8;
    localparam logic [3:0] OP_PWD_LOCK = 4'h9;
    localparam logic [3:0] OP_PWD_PROGRAM = 4'hA;
    localparam logic [3:0] OP_PWD_UNLOCK = 4'hB;
    localparam logic [3:0] OP_VERIFY = 4'hC;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 250;
    localparam int PROG_POLL_US = 1;
    localparam int ERASE_POLL_US = 50;
    localparam int PWD_CHECK_US = 2;
    localparam int PROG_POLL_CYC = PROG_POLL_US * CLK_MHZ;
    localparam int ERASE_POLL_CYC_DEF = ERASE_POLL_US * CLK_MHZ;
    localparam int PWD_CHECK_CYC = PWD_CHECK_US * CLK_MHZ;
    localparam int TIMER_W = 14;

    typedef struct packed {
        logic [SEC_W-1:0] sector;
        logic erase;
    } flps_grant_t;
endpackage : flps_pkg

// *** design/flps_protect.sv ***
// Sector protection decision logic with AXI4-Lite command and status registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Persistent method unless the password mode lock set
// - Either mode lock fixes method permanently
// - Write-protect pin works in both methods
// - Boot sectors single, middle sectors grouped
// - Nonvolatile bit per group, set individually
// - Nonvolatile erase clears all; host preprograms
// - One freeze bit locks nonvolatile bits
// - Freeze cleared only by reset or by password unlock
// - Volatile bit per sector, reset cleared
// - Protected is nonvolatile OR volatile bit
// - Freeze refuses nonvolatile program and erase
// - Nonvolatile bits persist, cleared only together
// - Volatile bits writable while frozen
// - Low write-protect pin blocks two sectors
// - Protected program or erase is ignored
// - Protected program polls about 1 us
// - Protected erase polls about 50 us
// - Verify reads volatile, nonvolatile, freeze bits
// - Delivered state all guard bits cleared
// - Password mode freeze comes up set
// - Password unlock clears freeze on match
// - Each password check takes 2 us
// - Persistent lock refuses password lock
module flps_protect #(
    parameter int ERASE_POLL_CYC = flps_pkg::ERASE_POLL_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic factoryInit,
    input wire logic wpPinN,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [flps_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [flps_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic grantValid,
    output flps_pkg::flps_grant_t grant,
    output logic busy
);
    import flps_pkg::*;

    // ****************************************
    // Sector decoding
    // ****************************************
    function automatic logic [GRP_W-1:0] grpOf(input logic [SEC_W-1:0] s);
        logic [SEC_W-1:0] d;
        d = s - 6'h0B;
        if (s <= BOOT_LO_LAST) begin
            grpOf = s[GRP_W-1:0];
        end else if (s >= BOOT_HI_FIRST) begin
            grpOf = GRP_W'(s - 6'h16);
        end else if (s <= MID_FIRST_GRP_END) begin
            grpOf = 5'h08;
        end else if (s >= MID_LAST_GRP_START) begin
            grpOf = 5'h0F;
        end else begin
            grpOf = GRP_W'(6'h09 + {2'h0, d[5:2]});
        end
    endfunction : grpOf

    function automatic logic isWpSec(input logic [SEC_W-1:0] s);
        isWpSec = (s == WP_SEC_A) || (s == WP_SEC_B);
    endfunction : isWpSec

    typedef enum logic [1:0] {ST_IDLE, ST_POLL, ST_CHECK} flps_state_t;

    flps_state_t state;
    logic [TIMER_W-1:0] timer;
    logic wpSync1;
    logic wpSync2;
    logic [GROUPS-1:0] nvBits;
    logic [SECTORS-1:0] volBits;
    logic freeze;
    logic persLock;
    logic pwdLock;
    logic [63:0] pwdStore;
    logic [63:0] pwdIn;
    logic pwdMatch;
    logic lastRefused;
    logic [SEC_W-1:0] verSec;
    logic wrFire;
    logic cmdFire;
    logic idleCmd;
    logic [3:0] op;
    logic [SEC_W-1:0] sec;
    logic secOk;
    logic wpLow;
    logic prot;
    logic writeMapped;
    logic readMapped;

    // ****************************************
    // Write-protect pin synchroniser
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wpSync1 <= 1'b1;
            wpSync2 <= 1'b1;
        end else begin
            wpSync1 <= wpPinN;
            wpSync2 <= wpSync1;
        end
    end
    assign wpLow = !wpSync2;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign writeMapped = (s_axi_awaddr == OFF_CMD) || (s_axi_awaddr == OFF_PWD_LO) ||
                         (s_axi_awaddr == OFF_PWD_HI);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Candidate password, byte lanes honoured
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : gPwdLane
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pwdIn[gb*8 +: 8] <= 8'h00;
                    pwdIn[32+gb*8 +: 8] <= 8'h00;
                end else if (wrFire && s_axi_wstrb[gb]) begin
                    if (s_axi_awaddr == OFF_PWD_LO) begin
                        pwdIn[gb*8 +: 8] <= s_axi_wdata[gb*8 +: 8];
                    end
                    if (s_axi_awaddr == OFF_PWD_HI) begin
                        pwdIn[32+gb*8 +: 8] <= s_axi_wdata[gb*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    assign cmdFire = wrFire && (s_axi_awaddr == OFF_CMD) && (&s_axi_wstrb[1:0]);
    assign op = s_axi_wdata[CMD_OP_LSB +: 4];
    assign sec = s_axi_wdata[CMD_SEC_LSB +: SEC_W];
    assign secOk = sec < SEC_W'(SECTORS);
    assign idleCmd = cmdFire && (state == ST_IDLE);

    // ****************************************
    // Protection decision
    // ****************************************
    assign prot = nvBits[grpOf(sec)] || volBits[sec] || (wpLow && isWpSec(sec));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            timer <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (idleCmd && secOk && prot && op == OP_PROGRAM) begin
                        state <= ST_POLL;
                        timer <= TIMER_W'(PROG_POLL_CYC - 1);
                    end else if (idleCmd && secOk && prot && op == OP_ERASE) begin
                        state <= ST_POLL;
                        timer <= TIMER_W'(ERASE_POLL_CYC - 1);
                    end else if (idleCmd && op == OP_PWD_UNLOCK && pwdLock) begin
                        state <= ST_CHECK;
                        timer <= TIMER_W'(PWD_CHECK_CYC - 1);
                    end
                end
                ST_POLL, ST_CHECK: begin
                    if (timer == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign busy = (state != ST_IDLE);

    // Compare once at command time so later password writes do not matter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwdMatch <= 1'b0;
        end else if (idleCmd && op == OP_PWD_UNLOCK) begin
            pwdMatch <= (pwdIn == pwdStore);
        end
    end

    // ****************************************
    // Guard bits
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            freeze <= pwdLock;
        end else if (idleCmd && op == OP_FREEZE_SET) begin
            freeze <= 1'b1;
        end else if (state == ST_CHECK && timer == '0 && pwdMatch) begin
            freeze <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            volBits <= '0;
        end else if (idleCmd && secOk && op == OP_VOL_SET) begin
            volBits[sec] <= 1'b1;
        end else if (idleCmd && secOk && op == OP_VOL_CLR) begin
            volBits[sec] <= 1'b0;
        end
    end

    // Nonvolatile state survives rst; factoryInit models a blank part
    always_ff @(posedge ref_clk) begin
        if (factoryInit) begin
            nvBits <= '0;
        end else if (idleCmd && !freeze && secOk && op == OP_NV_SET) begin
            nvBits[grpOf(sec)] <= 1'b1;
        end else if (idleCmd && !freeze && op == OP_NV_ERASE) begin
            nvBits <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (factoryInit) begin
            persLock <= 1'b0;
            pwdLock <= 1'b0;
        end else if (idleCmd && op == OP_PERS_LOCK && !pwdLock) begin
            persLock <= 1'b1;
        end else if (idleCmd && op == OP_PWD_LOCK && !persLock) begin
            pwdLock <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (factoryInit) begin
            pwdStore <= '0;
        end else if (idleCmd && op == OP_PWD_PROGRAM && !pwdLock) begin
            pwdStore <= pwdIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lastRefused <= 1'b0;
        end else if (cmdFire) begin
            lastRefused <= !idleCmd ||
                ((op == OP_PROGRAM || op == OP_ERASE) && (prot || !secOk)) ||
                ((op == OP_NV_SET || op == OP_NV_ERASE) && freeze) ||
                (op == OP_PWD_LOCK && persLock) || (op == OP_PERS_LOCK && pwdLock);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            verSec <= '0;
        end else if (idleCmd && secOk && op == OP_VERIFY) begin
            verSec <= sec;
        end
    end

    // ****************************************
    // Grant to the array sequencer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grantValid <= 1'b0;
            grant <= '0;
        end else begin
            grantValid <= idleCmd && secOk && !prot && (op == OP_PROGRAM || op == OP_ERASE);
            grant <= '{sector: sec, erase: (op == OP_ERASE)};
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign readMapped = (s_axi_araddr == OFF_CMD) || (s_axi_araddr == OFF_PWD_LO) ||
                        (s_axi_araddr == OFF_PWD_HI) || (s_axi_araddr == OFF_STATUS) ||
                        (s_axi_araddr == OFF_VERIFY);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == OFF_STATUS) begin
                s_axi_rdata <= {24'h0000_00, wpLow, pwdLock, persLock, freeze,
                                lastRefused, state == ST_CHECK, state == ST_POLL, busy};
            end else if (s_axi_araddr == OFF_VERIFY) begin
                s_axi_rdata <= {16'h0000, 2'h0, verSec, 5'h00, freeze,
                                nvBits[grpOf(verSec)], volBits[verSec]};
            end else begin
                s_axi_rdata <= '0;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    localparam int PROG_D = PROG_POLL_CYC;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_prog_poll_len: assert property (
        idleCmd && secOk && prot && op == OP_PROGRAM |-> ##PROG_D busy ##1 !busy)
        else $error("program poll length wrong");
    a_erase_poll_load: assert property (
        idleCmd && secOk && prot && op == OP_ERASE |=>
        state == ST_POLL && timer == TIMER_W'(ERASE_POLL_CYC - 1))
        else $error("erase poll not started");
    a_prot_no_grant: assert property (
        idleCmd && prot |=> !grantValid)
        else $error("protected sector granted");
    a_grant_unprot: assert property (
        grantValid |-> !(nvBits[grpOf(grant.sector)] || volBits[grant.sector]))
        else $error("grant to guarded sector");
    a_wp_blocks: assert property (
        grantValid |-> !($past(wpLow) && isWpSec(grant.sector)))
        else $error("write-protect pin ignored");
    a_freeze_holds_nv: assert property (
        freeze && !factoryInit |=> nvBits == $past(nvBits))
        else $error("frozen guard bits changed");
    a_freeze_clear_src: assert property (
        $fell(freeze) |-> $past(state == ST_CHECK && pwdMatch && pwdLock))
        else $error("freeze cleared without password");
    a_mode_exclusive: assert property (
        !(persLock && pwdLock))
        else $error("both mode locks set");
    a_vol_frozen_write: assert property (
        idleCmd && secOk && op == OP_VOL_SET |=> volBits[$past(sec)])
        else $error("volatile bit not set");
    a_pwd_check_time: assert property (
        idleCmd && op == OP_PWD_UNLOCK && pwdLock |=>
        state == ST_CHECK && timer == TIMER_W'(PWD_CHECK_CYC - 1))
        else $error("password check delay wrong");

    c_prot_poll: cover property (state == ST_IDLE ##1 state == ST_POLL);
    c_grant_issued: cover property (grantValid);
    c_pwd_unlock: cover property ($fell(freeze));
endmodule : flps_protect

`default_nettype wire

// *** sim/flps_flash_model.sv ***
// Flash array side: takes program and erase grants from the protection logic
`timescale 1ns/1ps
`default_nettype none
module flps_flash_model
    import flps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic grantValid,
    input wire flps_pkg::flps_grant_t grant,
    output logic [15:0] grantCount,
    output flps_pkg::flps_grant_t lastGrant
);
    // Counts granted operations; a refused one must never reach the array
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grantCount <= '0;
            lastGrant <= '0;
        end else if (grantValid === 1'b1) begin
            grantCount <= grantCount + 16'h1;
            lastGrant <= grant;
        end
    end
endmodule : flps_flash_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the sector protection block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flps_pkg::*;
    localparam int EP = 20;
    localparam logic [31:0] PW_LO = 32'h1234_5678;
    localparam logic [31:0] PW_HI = 32'h9ABC_DEF0;
    logic ref_clk = 0, rst = 1, factoryInit = 1, wpPinN = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic grantValid, busy;
    flps_grant_t grant, lastGrant;
    logic [15:0] grantCount;
    int nErrors = 0, cmpCount = 0, busyRun = 0, lastBusy = 0;

    flps_protect #(.ERASE_POLL_CYC(EP)) i_dut (.ref_clk, .rst, .factoryInit, .wpPinN,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .grantValid, .grant, .busy);
    flps_flash_model i_flash (.ref_clk, .rst, .grantValid, .grant, .grantCount, .lastGrant);

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Length of the last busy stretch
    always @(posedge ref_clk) begin
        if (rst) begin
            busyRun <= 0;
        end else if (busy === 1'b1) begin
            busyRun <= busyRun + 1;
        end else if (busyRun != 0) begin
            lastBusy <= busyRun;
            busyRun <= 0;
        end
    end

    task automatic report_and_stop();
        if (nErrors == 0 && cmpCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask : chk_resp

    task automatic tick(inout int n);
        @(posedge ref_clk);
        n++;
        if (n > 2000) begin
            nErrors++;
            report_and_stop();
        end
    endtask : tick

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw, w;
        int n;
        aw = 1;
        w = 1;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (aw || w) begin
            tick(n);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 0;
                s_axi_awvalid <= 0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 0;
                s_axi_wvalid <= 0;
            end
        end
        s_axi_bready <= 1;
        do tick(n); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk_resp(s_axi_bresp, e);
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do tick(n); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        do tick(n); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rreg

    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0) tick(n);
        tick(n);
    endtask : idle

    task automatic cmd(input logic [3:0] op, input logic [5:0] s);
        idle();
        wreg(OFF_CMD, {18'h0, s, 4'h0, op}, RESP_OKAY);
    endtask : cmd

    // Program or erase attempt: bl is 0 when a grant is due, else the busy length
    task automatic pe(input logic [3:0] op, input logic [5:0] s, input int bl);
        logic [15:0] c;
        c = grantCount;
        cmd(op, s);
        idle();
        chk({16'h0, grantCount}, {16'h0, c + 16'(bl == 0)});
        if (bl == 0) chk({25'h0, lastGrant}, {25'h0, s, op == OP_ERASE});
        else chk(32'(lastBusy), 32'(bl));
    endtask : pe

    task automatic vfy(input logic [5:0] s, input logic [2:0] e);
        logic [31:0] d;
        logic [1:0] r;
        cmd(OP_VERIFY, s);
        rreg(OFF_VERIFY, d, r);
        chk_resp(r, RESP_OKAY);
        chk(d, {18'h0, s, 5'h0, e});
    endtask : vfy

    // e is wpLow, pwdLock, persLock, freeze
    task automatic stat(input logic [3:0] e);
        logic [31:0] d;
        logic [1:0] r;
        idle();
        rreg(OFF_STATUS, d, r);
        chk({25'h0, d[7:4], d[2:0]}, {25'h0, e, 3'h0});
    endtask : stat

    task automatic do_reset(input logic fi);
        rst <= 1;
        factoryInit <= fi;
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        factoryInit <= 0;
        @(posedge ref_clk);
    endtask : do_reset

    task automatic set_wp(input logic v);
        wpPinN <= v;
        repeat (3) @(posedge ref_clk);
    endtask : set_wp

    initial begin : main
        logic [31:0] d;
        logic [1:0] r;
        do_reset(1'b1);
        // ****************************************
        // Blank part, persistent method
        // ****************************************
        stat(4'h0);
        for (int s = 0; s < SECTORS; s += 9) vfy(6'(s), 3'h0);
        rreg(8'h40, d, r);
        chk_resp(r, RESP_SLVERR);
        chk(d, 32'h0);
        wreg(8'h44, 32'h0, RESP_SLVERR);
        pe(OP_PROGRAM, 6'd45, 0);
        cmd(OP_VOL_SET, 6'd20);
        vfy(6'd20, 3'h1);
        pe(OP_PROGRAM, 6'd20, PROG_POLL_CYC);
        pe(OP_ERASE, 6'd20, EP);
        pe(OP_PROGRAM, 6'd21, 0);
        cmd(OP_VOL_CLR, 6'd20);
        pe(OP_ERASE, 6'd20, 0);
        cmd(OP_NV_SET, 6'd9);
        vfy(6'd8, 3'h2);
        pe(OP_PROGRAM, 6'd10, PROG_POLL_CYC);
        pe(OP_ERASE, 6'd11, 0);
        cmd(OP_NV_SET, 6'd6);
        vfy(6'd7, 3'h0);
        set_wp(1'b0);
        stat(4'h8);
        pe(OP_PROGRAM, WP_SEC_A, PROG_POLL_CYC);
        pe(OP_ERASE, WP_SEC_B, EP);
        pe(OP_PROGRAM, 6'd2, 0);
        cmd(OP_FREEZE_SET, 6'd0);
        stat(4'h9);
        cmd(OP_NV_SET, 6'd30);
        vfy(6'd30, 3'h4);
        cmd(OP_NV_ERASE, 6'd0);
        vfy(6'd9, 3'h6);
        cmd(OP_VOL_SET, 6'd30);
        vfy(6'd30, 3'h5);
        cmd(OP_PWD_UNLOCK, 6'd0);
        stat(4'h9);
        set_wp(1'b1);
        do_reset(1'b0);
        stat(4'h0);
        vfy(6'd9, 3'h2);
        vfy(6'd30, 3'h0);
        for (int s = 0; s < SECTORS; s++) cmd(OP_NV_SET, 6'(s));
        cmd(OP_NV_ERASE, 6'd0);
        vfy(6'd45, 3'h0);
        pe(OP_PROGRAM, 6'd10, 0);
        // ****************************************
        // Mode locks
        // ****************************************
        cmd(OP_PERS_LOCK, 6'd0);
        cmd(OP_PWD_LOCK, 6'd0);
        stat(4'h2);
        do_reset(1'b0);
        stat(4'h2);
        do_reset(1'b1);
        wreg(OFF_PWD_LO, PW_LO, RESP_OKAY);
        wreg(OFF_PWD_HI, PW_HI, RESP_OKAY);
        cmd(OP_PWD_PROGRAM, 6'd0);
        cmd(OP_PWD_LOCK, 6'd0);
        cmd(OP_PERS_LOCK, 6'd0);
        do_reset(1'b0);
        stat(4'h5);
        cmd(OP_NV_SET, 6'd12);
        vfy(6'd12, 3'h4);
        set_wp(1'b0);
        pe(OP_PROGRAM, WP_SEC_A, PROG_POLL_CYC);
        set_wp(1'b1);
        wreg(OFF_PWD_LO, ~PW_LO, RESP_OKAY);
        wreg(OFF_PWD_HI, PW_HI, RESP_OKAY);
        cmd(OP_PWD_UNLOCK, 6'd0);
        idle();
        chk(32'(lastBusy), 32'(PWD_CHECK_CYC));
        stat(4'h5);
        wreg(OFF_PWD_LO, PW_LO, RESP_OKAY);
        cmd(OP_PWD_UNLOCK, 6'd0);
        stat(4'h4);
        cmd(OP_NV_SET, 6'd12);
        vfy(6'd12, 3'h2);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
